// File: design/serial_consts.svh
`ifndef SERIAL_CONSTS_SVH
`define SERIAL_CONSTS_SVH

// System clock and derived rates, in Hz, and the receive oversample factor
`define CLK_HZ             50000000
`define MOD_CLK_HZ         4800
`define TIMEOUT_GAP_HZ     3200
`define BASE_BAUD          300
`define PLL_NOMINAL_HZ     38400
`define RX_OVERSAMPLE      16

// Register indices; byte address is four times the index
`define REG_IDX_CTRL       1'b0
`define REG_IDX_DATA       1'b1
`define REG_SEL_BIT        2
`define JUMPER_LSB         3
`define JUMPER_W           7

// Control port fields
`define CTRL_PATH_BIT      0
`define CTRL_STOP_BIT      1
`define CTRL_PLAYER_BIT    0
`define CTRL_RECORDER_BIT  1

// Status port fields
`define STAT_TX_EMPTY_BIT  7
`define STAT_DAV_BIT       6
`define STAT_OVERRUN_BIT   5
`define STAT_FRAMING_BIT   4

`endif

// File: design/serial_pkg.sv
package serial_pkg;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;

    typedef struct packed {
        logic       tx_empty;
        logic       data_avail;
        logic       overrun;
        logic       framing;
        logic [3:0] spare;
    } status_type;

    typedef struct packed {
        logic path_select;
        logic stop_count;
        logic player_relay;
        logic recorder_relay;
    } ctrl_type;

endpackage

// File: design/serial_tx.sv
`timescale 1ns/1ps
module serial_tx (
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       load_in,
    input  wire logic [7:0] data_in,
    input  wire logic       bit_tick_in,
    input  wire logic       two_stop_in,
    output logic            serial_out,
    output logic            empty_out
);
    logic [7:0] hold_reg,   hold_next;
    logic       full_reg,   full_next;
    logic [8:0] frame_reg,  frame_next;
    logic [3:0] count_reg,  count_next;
    logic       serial_reg, serial_next;
    logic       take;

    // Holding buffer feeds the shifter; a load in the take cycle survives
    always_comb
    begin
        take        = bit_tick_in && count_reg == 4'h0 && full_reg;
        hold_next   = load_in ? data_in : hold_reg;
        full_next   = load_in ? 1'b1 : (take ? 1'b0 : full_reg);
        frame_next  = frame_reg;
        count_next  = count_reg;
        serial_next = serial_reg;
        if (take)
        begin
            serial_next = 1'b0;
            frame_next  = {1'b1, hold_reg};
            count_next  = two_stop_in ? 4'ha : 4'h9;
        end
        else if (bit_tick_in && count_reg != 4'h0)
        begin
            serial_next = frame_reg[0];
            frame_next  = {1'b1, frame_reg[8:1]};
            count_next  = count_reg - 4'h1;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            hold_reg   <= 8'h00;
            full_reg   <= 1'b0;
            frame_reg  <= 9'h1ff;
            count_reg  <= 4'h0;
            serial_reg <= 1'b1;
        end
        else
        begin
            hold_reg   <= hold_next;
            full_reg   <= full_next;
            frame_reg  <= frame_next;
            count_reg  <= count_next;
            serial_reg <= serial_next;
        end
    end

    assign serial_out = serial_reg;
    assign empty_out  = ~full_reg;

    default clocking tx_cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    AST_START_BIT: assert property (take |=> !serial_reg ##0 count_reg >= 4'h9)
        else $error("start bit not sent on take");
    AST_STOP_COUNT: assert property (take && two_stop_in |=> count_reg == 4'ha)
        else $error("two stop bits not loaded");
endmodule // serial_tx

// File: design/cassette_demod.sv
`timescale 1ns/1ps
module cassette_demod #(
    parameter int EDGE_TIMEOUT_CYCLES = 15625,
    parameter int PLL_NOMINAL_CYCLES  = 1302
) (
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       tape_in,
    input  wire logic [1:0] rate_in,
    output logic            data_out,
    output logic            rx_tick_out
);
    localparam int TW = $clog2(EDGE_TIMEOUT_CYCLES + 1);
    logic [2:0]    sq_reg,      sq_next;
    logic          edge_reg,    edge_next;
    logic [TW-1:0] tmo_reg,     tmo_next;
    logic          data_reg,    data_next;
    logic          half_reg,    half_next;
    logic          rec_reg,     rec_next;
    logic [15:0]   per_reg,     per_next;
    logic [11:0]   oper_reg,    oper_next;
    logic [11:0]   ocnt_reg,    ocnt_next;
    logic [3:0]    chain_reg,   chain_next;
    logic          tick_reg,    tick_next;
    logic          expired;
    logic          osc_tick;

    // Edge pulse, timeout, data flop, clock recovery and tracking oscillator
    always_comb
    begin
        sq_next   = {sq_reg[1:0], tape_in};
        edge_next = sq_reg[2] ^ sq_reg[1];
        expired   = tmo_reg == TW'(EDGE_TIMEOUT_CYCLES);
        tmo_next  = edge_reg ? '0 : (expired ? tmo_reg : tmo_reg + 1'b1);
        data_next = edge_reg ? ~expired : data_reg;
        half_next = half_reg;
        rec_next  = 1'b0;
        if (edge_reg)
        begin
            half_next = expired ? 1'b0 : ~half_reg;
            rec_next  = expired | half_reg;
        end
        // Period tracking stands in for the analogue loop filter
        per_next  = rec_reg ? 16'h0001 : (&per_reg ? per_reg : per_reg + 16'h0001);
        oper_next = oper_reg;
        if (rec_reg && per_reg[15:4] != 12'h000)
            oper_next = per_reg[15:4];
        osc_tick  = ocnt_reg + 12'h001 >= oper_reg;
        ocnt_next = (rec_reg || osc_tick) ? 12'h000 : ocnt_reg + 12'h001;
        chain_next = rec_reg ? 4'h0 : (osc_tick ? chain_reg + 4'h1 : chain_reg);
        unique case (rate_in)
            2'd0: tick_next = osc_tick && chain_reg[2:0] == 3'h7;
            2'd1: tick_next = osc_tick && chain_reg[1:0] == 2'h3;
            2'd2: tick_next = osc_tick && chain_reg[0];
            2'd3: tick_next = osc_tick;
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sq_reg    <= 3'h0;
            edge_reg  <= 1'b0;
            tmo_reg   <= '0;
            data_reg  <= 1'b1;
            half_reg  <= 1'b0;
            rec_reg   <= 1'b0;
            per_reg   <= 16'h0000;
            oper_reg  <= 12'(PLL_NOMINAL_CYCLES);
            ocnt_reg  <= 12'h000;
            chain_reg <= 4'h0;
            tick_reg  <= 1'b0;
        end
        else
        begin
            sq_reg    <= sq_next;
            edge_reg  <= edge_next;
            tmo_reg   <= tmo_next;
            data_reg  <= data_next;
            half_reg  <= half_next;
            rec_reg   <= rec_next;
            per_reg   <= per_next;
            oper_reg  <= oper_next;
            ocnt_reg  <= ocnt_next;
            chain_reg <= chain_next;
            tick_reg  <= tick_next;
        end
    end

    assign data_out    = data_reg;
    assign rx_tick_out = tick_reg;

    default clocking dm_cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    AST_DATA_HIGH: assert property (edge_reg && !expired |=> data_reg)
        else $error("data not high under fast edges");
    AST_DATA_LOW: assert property (edge_reg && expired |=> !data_reg ##0 rec_reg)
        else $error("data not low after timeout");
endmodule // cassette_demod

// File: design/cassette_terminal_serial_port.sv
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "serial_consts.svh"
module cassette_terminal_serial_port #(
    parameter int MOD_TICK_CYCLES     = `CLK_HZ / `MOD_CLK_HZ,
    parameter int BIT_CYCLES_BASE     = `CLK_HZ / `BASE_BAUD,
    parameter int EDGE_TIMEOUT_CYCLES = `CLK_HZ / `TIMEOUT_GAP_HZ,
    parameter int PLL_NOMINAL_CYCLES  = `CLK_HZ / `PLL_NOMINAL_HZ
) (
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic [6:0]  jumper_direct_in,
    input  wire logic [2:0]  terminal_rate_in,
    input  wire logic [1:0]  cassette_rate_in,
    input  wire logic        terminal_rx_in,
    input  wire logic        tape_in,
    output logic             terminal_tx_out,
    output logic             tone_out,
    output logic             player_relay_out,
    output logic             recorder_relay_out
);
    localparam int CW = $clog2(BIT_CYCLES_BASE + 1);
    localparam int MW = $clog2(MOD_TICK_CYCLES + 1);
    localparam int SW = `JUMPER_W + 3 + 2 + 1;

    logic [SW-1:0]             sync_a_reg, sync_b_reg;
    logic [`JUMPER_W-1:0]      jumper_s;
    logic [2:0]                term_rate_s;
    logic [1:0]                cas_rate_s;
    logic                      term_rx_s;
    serial_pkg::ctrl_type      ctrl_reg, ctrl_next;
    logic                      pready_reg, pready_next;
    logic                      pslverr_reg, pslverr_next;
    logic [31:0]               prdata_reg, prdata_next;
    logic                      access, sel_data, match, done;
    logic                      tx_load, rd_data;
    serial_pkg::status_type    status;
    logic [CW-1:0]             tx_cnt_reg, tx_cnt_next;
    logic [CW-1:0]             rxt_cnt_reg, rxt_cnt_next;
    logic [CW-1:0]             tx_limit, rxt_limit;
    logic [2:0]                term_shift, tx_shift;
    logic                      tx_tick, rxt_tick;
    logic [MW-1:0]             mod_cnt_reg, mod_cnt_next;
    logic                      mod_tick;
    logic                      gate_reg, gate_next;
    logic                      tone_reg, tone_next;
    logic                      tx_serial, tx_empty;
    logic                      cas_data, cas_tick;
    logic                      rx_bit, rx_tick;
    serial_pkg::rx_state_type  rx_state_reg, rx_state_next;
    logic [3:0]                rx_cnt_reg, rx_cnt_next;
    logic [2:0]                rx_idx_reg, rx_idx_next;
    logic [7:0]                rx_shift_reg, rx_shift_next;
    logic [7:0]                rx_data_reg, rx_data_next;
    logic                      dav_reg, dav_next;
    logic                      ovr_reg, ovr_next;
    logic                      frm_reg, frm_next;
    logic                      rx_done;

    // Straps and the terminal line come from pins: two flops before use
    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sync_a_reg <= SW'(1);                 // Line bit idles high: no false start
            sync_b_reg <= SW'(1);
        end
        else
        begin
            sync_a_reg <= {jumper_direct_in, terminal_rate_in, cassette_rate_in,
                           terminal_rx_in};
            sync_b_reg <= sync_a_reg;
        end
    end
    assign {jumper_s, term_rate_s, cas_rate_s, term_rx_s} = sync_b_reg;

    // Bus decode: one wait state, so read data is built before pready
    assign access   = psel_in && penable_in;
    assign sel_data = paddr_in[`REG_SEL_BIT] == `REG_IDX_DATA;
    assign match    = paddr_in[`JUMPER_LSB +: `JUMPER_W] == jumper_s;
    assign done     = access && pready_reg;
    assign tx_load  = done && pwrite_in && match && sel_data;
    assign rd_data  = done && !pwrite_in && match && sel_data;

    always_comb
    begin
        status            = '0;
        status.tx_empty   = tx_empty;
        status.data_avail = dav_reg;
        status.overrun    = ovr_reg;
        status.framing    = frm_reg;
        pready_next       = access && !pready_reg;
        pslverr_next      = access && !pready_reg && !match;
        prdata_next       = 32'h0000_0000;
        if (access && !pready_reg && match && !pwrite_in)
            prdata_next = sel_data ? {24'h00_0000, rx_data_reg}
                                   : {24'h00_0000, status};
        ctrl_next = ctrl_reg;
        if (done && pwrite_in && match && !sel_data)
        begin
            ctrl_next.path_select    = pwdata_in[`CTRL_PATH_BIT];
            ctrl_next.stop_count     = pwdata_in[`CTRL_STOP_BIT];
            ctrl_next.player_relay   = pwdata_in[`CTRL_PLAYER_BIT];
            ctrl_next.recorder_relay = pwdata_in[`CTRL_RECORDER_BIT];
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ctrl_reg    <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end
        else
        begin
            ctrl_reg    <= ctrl_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg  <= prdata_next;
        end
    end

    // Bit clocks: terminal strap saturates at 9600 baud
    always_comb
    begin
        term_shift   = term_rate_s > 3'd5 ? 3'd5 : term_rate_s;
        tx_shift     = ctrl_reg.path_select ? {1'b0, cas_rate_s} : term_shift;
        tx_limit     = CW'(BIT_CYCLES_BASE) >> tx_shift;
        rxt_limit    = (CW'(BIT_CYCLES_BASE) >> term_shift) >> 4;
        tx_tick      = tx_cnt_reg + 1'b1 >= tx_limit;
        rxt_tick     = rxt_cnt_reg + 1'b1 >= rxt_limit;
        tx_cnt_next  = tx_tick ? '0 : tx_cnt_reg + 1'b1;
        rxt_cnt_next = rxt_tick ? '0 : rxt_cnt_reg + 1'b1;
        mod_tick     = mod_cnt_reg + 1'b1 >= MW'(MOD_TICK_CYCLES);
        mod_cnt_next = mod_tick ? '0 : mod_cnt_reg + 1'b1;
        // Modulator: a one forces the gate high, a zero lets it toggle
        gate_next = gate_reg;
        tone_next = tone_reg;
        if (mod_tick)
        begin
            gate_next = tx_serial ? 1'b1 : ~gate_reg;
            if (tx_serial || gate_reg)
                tone_next = ~tone_reg;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            tx_cnt_reg  <= '0;
            rxt_cnt_reg <= '0;
            mod_cnt_reg <= '0;
            gate_reg    <= 1'b1;
            tone_reg    <= 1'b0;
        end
        else
        begin
            tx_cnt_reg  <= tx_cnt_next;
            rxt_cnt_reg <= rxt_cnt_next;
            mod_cnt_reg <= mod_cnt_next;
            gate_reg    <= gate_next;
            tone_reg    <= tone_next;
        end
    end

    serial_tx u_tx (
        .clk_in      (clk_in),
        .reset_n_in  (reset_n_in),
        .load_in     (tx_load),
        .data_in     (pwdata_in[7:0]),
        .bit_tick_in (tx_tick),
        .two_stop_in (ctrl_reg.stop_count),
        .serial_out  (tx_serial),
        .empty_out   (tx_empty)
    );

    cassette_demod #(
        .EDGE_TIMEOUT_CYCLES (EDGE_TIMEOUT_CYCLES),
        .PLL_NOMINAL_CYCLES  (PLL_NOMINAL_CYCLES)
    ) u_demod (
        .clk_in      (clk_in),
        .reset_n_in  (reset_n_in),
        .tape_in     (tape_in),
        .rate_in     (cas_rate_s),
        .data_out    (cas_data),
        .rx_tick_out (cas_tick)
    );

    // Receiver: input and clock both follow the path latch
    assign rx_bit  = ctrl_reg.path_select ? cas_data : term_rx_s;
    assign rx_tick = ctrl_reg.path_select ? cas_tick : rxt_tick;

    always_comb
    begin
        rx_state_next = rx_state_reg;
        rx_cnt_next   = rx_cnt_reg;
        rx_idx_next   = rx_idx_reg;
        rx_shift_next = rx_shift_reg;
        rx_data_next  = rx_data_reg;
        rx_done       = 1'b0;
        frm_next      = frm_reg;
        if (rx_tick)
        begin
            rx_cnt_next = rx_cnt_reg + 4'h1;
            unique case (rx_state_reg)
                serial_pkg::RX_IDLE:
                begin
                    rx_cnt_next = 4'h0;
                    if (!rx_bit)
                        rx_state_next = serial_pkg::RX_START;
                end
                serial_pkg::RX_START:
                    if (rx_cnt_reg == 4'h7)
                    begin
                        rx_cnt_next   = 4'h0;
                        rx_idx_next   = 3'h0;
                        rx_state_next = rx_bit ? serial_pkg::RX_IDLE : serial_pkg::RX_DATA;
                    end
                serial_pkg::RX_DATA:
                    if (rx_cnt_reg == 4'hf)
                    begin
                        rx_shift_next = {rx_bit, rx_shift_reg[7:1]};
                        rx_idx_next   = rx_idx_reg + 3'h1;
                        if (rx_idx_reg == 3'h7)
                            rx_state_next = serial_pkg::RX_STOP;
                    end
                serial_pkg::RX_STOP:
                    if (rx_cnt_reg == 4'hf)
                    begin
                        rx_data_next  = rx_shift_reg;
                        rx_done       = 1'b1;
                        frm_next      = !rx_bit;
                        rx_state_next = serial_pkg::RX_IDLE;
                    end
            endcase
        end
        // A character landing in the read cycle keeps its flag set
        dav_next = rx_done ? 1'b1 : (rd_data ? 1'b0 : dav_reg);
        ovr_next = rx_done ? dav_reg : ovr_reg;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rx_state_reg <= serial_pkg::RX_IDLE;
            rx_cnt_reg   <= 4'h0;
            rx_idx_reg   <= 3'h0;
            rx_shift_reg <= 8'h00;
            rx_data_reg  <= 8'h00;
            dav_reg      <= 1'b0;
            ovr_reg      <= 1'b0;
            frm_reg      <= 1'b0;
        end
        else
        begin
            rx_state_reg <= rx_state_next;
            rx_cnt_reg   <= rx_cnt_next;
            rx_idx_reg   <= rx_idx_next;
            rx_shift_reg <= rx_shift_next;
            rx_data_reg  <= rx_data_next;
            dav_reg      <= dav_next;
            ovr_reg      <= ovr_next;
            frm_reg      <= frm_next;
        end
    end

    assign prdata_out         = prdata_reg;
    assign pready_out         = pready_reg;
    assign pslverr_out        = pslverr_reg;
    assign terminal_tx_out    = tx_serial;
    assign tone_out           = tone_reg;
    assign player_relay_out   = ctrl_reg.player_relay;
    assign recorder_relay_out = ctrl_reg.recorder_relay;

    default clocking top_cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    AST_WRITE_CTRL: assert property (done && pwrite_in && match && !sel_data
        |=> ctrl_reg.stop_count == $past(pwdata_in[`CTRL_STOP_BIT]))
        else $error("control latch not loaded");
    AST_WRITE_DATA: assert property (tx_load |=> !tx_empty)
        else $error("transmit buffer not loaded");
    AST_READ_DATA: assert property (rd_data |-> prdata_out[7:0] == $past(rx_data_reg))
        else $error("data read mismatch");
    AST_READ_STATUS: assert property (done && !pwrite_in && match && !sel_data
        |-> prdata_out[`STAT_DAV_BIT] == $past(dav_reg))
        else $error("status read mismatch");
    AST_DAV_CLEAR: assert property (rd_data && !rx_done |=> !dav_reg)
        else $error("data available not cleared");
    AST_NO_MATCH: assert property (done && !match |-> pslverr_out && prdata_out == 32'h0)
        else $error("unmatched address answered");
    AST_TONE_ONE: assert property (mod_tick && tx_serial |=> tone_reg != $past(tone_reg))
        else $error("high tone missed a toggle");
    AST_TONE_ZERO: assert property (mod_tick && !tx_serial && !gate_reg
        |=> tone_reg == $past(tone_reg) ##0 gate_reg)
        else $error("low tone did not skip a toggle");

    COV_TX_LOAD:   cover property (tx_load);
    COV_RX_DONE:   cover property (rx_done && ctrl_reg.path_select);
    COV_READ_DATA: cover property (rd_data && dav_reg);
    COV_TWO_STOP:  cover property (tx_load && ctrl_reg.stop_count);
endmodule // cassette_terminal_serial_port

// File: sim/far_end_model.sv
`timescale 1ns/1ps
module far_end_model (
    input  wire logic tx_line_in,
    input  wire logic tone_in,
    output logic      rx_line_out,
    output logic      tape_out
);
    // Terminal echoes its line, recorder plays back what it records
    assign rx_line_out = tx_line_in;
    assign tape_out    = tone_in;
endmodule // far_end_model

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clk_in, reset_n_in, psel, penable, pwrite, pready, pslverr, er;
    logic        t_tx, t_rx, tone, tape, ply, rec;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  chars [3] = '{8'h00, 8'ha5, 8'hf0};
    logic [6:0]  jmp;
    logic [2:0]  trate;
    logic [1:0]  crate;
    int          n_fail, cmp_count, cyc, n;

    cassette_terminal_serial_port #(.MOD_TICK_CYCLES(16), .BIT_CYCLES_BASE(256),
        .EDGE_TIMEOUT_CYCLES(24), .PLL_NOMINAL_CYCLES(8)) uut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .jumper_direct_in(jmp),
        .terminal_rate_in(trate), .cassette_rate_in(crate), .terminal_rx_in(t_rx),
        .tape_in(tape), .terminal_tx_out(t_tx), .tone_out(tone),
        .player_relay_out(ply), .recorder_relay_out(rec));
    far_end_model partner (.tx_line_in(t_tx), .tone_in(tone), .rx_line_out(t_rx),
        .tape_out(tape));

    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // Cuts a hang short; all tests fit well inside this
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_fail++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer, request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Clock cycles between two tone toggles
    task automatic half(output int c);
        logic t;
        c = 0;
        @(posedge clk_in);
        t = tone;
        while (tone === t) @(posedge clk_in);
        t = tone;
        while (tone === t)
        begin
            c++;
            @(posedge clk_in);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        {reset_n_in, psel, penable, pwrite, paddr, pwdata} = '0;
        {n_fail, cmp_count, cyc} = '0;
        {jmp, trate, crate} = {7'h05, 3'h0, 2'h0};
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        apb(1'b0, 12'h028, 32'h0);
        chk("status", 32'h80, rd);
        chk("relays", 32'h0, {rec, ply});
        apb(1'b1, 12'h028, 32'h3);
        apb(1'b0, 12'h030, 32'h0);
        chk("mismatch_err", 32'h1, er);
        chk("mismatch_data", 32'h0, rd);
        chk("relays", 32'h3, {rec, ply});
        apb(1'b1, 12'h028, 32'h0);
        half(n);
        chk("idle_tone", 32'd16, n);
        foreach (chars[i])
        begin
            // Last character loops over tape; strap moved apart so a wrong mux shows
            if (i == 2)
            begin
                trate <= 3'h1;
                apb(1'b1, 12'h028, 32'h3);
            end
            apb(1'b1, 12'h02c, {24'h0, chars[i]});
            if (i == 0)
            begin
                repeat (300) @(posedge clk_in);
                half(n);
                chk("zero_tone", 32'd32, n);
            end
            n = 0;
            do
            begin
                apb(1'b0, 12'h028, 32'h0);
                n++;
            end while (rd[6] !== 1'b1 && n < 2000);
            chk("rx_flags", 32'h0, rd[5:4]);
            apb(1'b0, 12'h02c, 32'h0);
            chk("rx_byte", {24'h0, chars[i]}, rd);
            apb(1'b0, 12'h028, 32'h0);
            chk("dav_clear", 32'h0, rd[6]);
        end
        summarize();
    end
endmodule // testbench
